// ---- acc_pkg.sv ----
// Constants shared by the comparator control block.
// Assumes an 8-bit register port and a single 125 MHz clock.
package acc_pkg;
  localparam logic [2:0] ADDR_PRIMARY_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_INPUT_SELECT    = 3'h2;
  localparam logic [2:0] ADDR_REFERENCE_DIV   = 3'h4;
  localparam logic [2:0] ADDR_INTERRUPT_EN    = 3'h6;
  localparam logic [2:0] ADDR_STATUS          = 3'h7;
  localparam logic [2:0] ADDR_INT_MASK        = 3'h5;

  localparam logic [7:0] RST_PRIMARY_CONTROL = 8'h00;
  localparam logic [7:0] RST_INPUT_SELECT    = 8'h00;
  localparam logic [7:0] RST_REFERENCE_DIV   = 8'hFF;
  localparam logic [7:0] RST_INTERRUPT_EN    = 8'h00;
  localparam logic [7:0] RST_INT_MASK        = 8'h01;

  localparam int BIT_ENABLE      = 0;
  localparam int BIT_HYS_LO      = 1;
  localparam int BIT_LOW_POWER   = 3;
  localparam int BIT_EDGE_LO     = 4;
  localparam int BIT_PIN_DRIVE   = 6;
  localparam int BIT_STANDBY_RUN = 7;
  localparam int BIT_NEG_LO      = 0;
  localparam int BIT_POS_LO      = 3;
  localparam int BIT_INVERT      = 7;
  localparam int BIT_FLAG        = 0;
  localparam int BIT_STATE       = 4;

  localparam int SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    ACC_EDGE_ANY      = 2'b00,
    ACC_EDGE_RESERVED = 2'b01,
    ACC_EDGE_FALL     = 2'b10,
    ACC_EDGE_RISE     = 2'b11
  } acc_edge_t;
endpackage

// ---- acc_sync.sv ----
// Multi-stage level synchroniser for the asynchronous comparator output.
// Assumes only the last stage is read outside.
`timescale 1ns/1ps
`default_nettype none
module acc_sync #(
  parameter int STAGES = 3
) (
  input  wire logic clk_sys, // System clock
  input  wire logic rst_b,   // Async reset, active low
  input  wire logic d_in,    // Asynchronous level
  output var  logic q_out    // Synchronised level
);
  logic [STAGES-1:0] sync_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync_r <= '0;
    end else begin
      sync_r <= {sync_r[STAGES-2:0], d_in};
    end
  end

  assign q_out = sync_r[STAGES-1];
endmodule
`default_nettype wire

// ---- acc_comparator_ctrl.sv ----
// Register and control logic around an analog comparator core.
// Assumes the core and pin muxes are analog; core output is asynchronous.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module acc_comparator_ctrl (
  input  wire logic       clk_sys,        // System clock, 125 MHz
  input  wire logic       rst_b,          // Async reset, active low
  input  wire logic [2:0] reg_addr,       // Register address
  input  wire logic [7:0] reg_wdata,      // Write data
  input  wire logic       reg_wr,         // Write strobe
  input  wire logic       reg_rd,         // Read strobe
  output var  logic [7:0] reg_rdata,      // Read data, cycle after strobe
  input  wire logic       standby,        // Chip in standby sleep
  input  wire logic       core_out,       // Raw comparator result, async
  output var  logic       core_enable,    // Comparator core power on
  output var  logic [1:0] hysteresis_select,    // Hysteresis level to core
  output var  logic       low_power_select,     // Low-power mode to core
  output var  logic [1:0] positive_input_select, // Positive mux select
  output var  logic [1:0] negative_input_select, // Negative mux select
  output var  logic [7:0] divided_reference_level, // Reference divider code
  output var  logic       core_invert,    // Analog-path output inversion
  output var  logic       out_pin_o,      // Comparator output pin value
  output var  logic       out_pin_oe_b,   // Output pin enable, active low
  output var  logic       irq             // Interrupt request, level
);
  logic [7:0] primary_control_r;
  logic [7:0] input_select_r;
  logic [7:0] reference_div_r;
  logic [7:0] interrupt_enable_r;
  logic [7:0] int_mask_r;
  logic       flag_r;
  logic       state_prev_r;
  logic       core_sync;
  logic       state_now;
  logic       enabled;
  logic       edge_hit;
  logic       flag_nxt;
  acc_pkg::acc_edge_t edge_mode;

  function automatic logic wr_hit(input logic [2:0] a, input logic [2:0] target);
    wr_hit = reg_wr && (a == target);
  endfunction

  // Without standby run the block halts in standby sleep.
  assign enabled = primary_control_r[acc_pkg::BIT_ENABLE] &&
                   (!standby || primary_control_r[acc_pkg::BIT_STANDBY_RUN]);

  acc_sync #(
    .STAGES (acc_pkg::SYNC_STAGES)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .d_in    (core_out),
    .q_out   (core_sync)
  );

  assign state_now = core_sync ^ input_select_r[acc_pkg::BIT_INVERT];
  assign edge_mode = acc_pkg::acc_edge_t'(primary_control_r[acc_pkg::BIT_EDGE_LO +: 2]);

  always_comb begin
    edge_hit = 1'b0;
    unique case (edge_mode)
      acc_pkg::ACC_EDGE_ANY:      edge_hit = state_now ^ state_prev_r;
      acc_pkg::ACC_EDGE_FALL:     edge_hit = state_prev_r && !state_now;
      acc_pkg::ACC_EDGE_RISE:     edge_hit = !state_prev_r && state_now;
      acc_pkg::ACC_EDGE_RESERVED: edge_hit = 1'b0;
    endcase
    edge_hit = edge_hit && enabled;
  end

  // Primary control
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      primary_control_r <= acc_pkg::RST_PRIMARY_CONTROL;
    end else if (wr_hit(reg_addr, acc_pkg::ADDR_PRIMARY_CONTROL)) begin
      primary_control_r <= reg_wdata;
    end
  end

  // Input select; bits 6:5 and 2 are not implemented
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      input_select_r <= acc_pkg::RST_INPUT_SELECT;
    end else if (wr_hit(reg_addr, acc_pkg::ADDR_INPUT_SELECT)) begin
      input_select_r <= reg_wdata & 8'h9B;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reference_div_r <= acc_pkg::RST_REFERENCE_DIV;
    end else if (wr_hit(reg_addr, acc_pkg::ADDR_REFERENCE_DIV)) begin
      reference_div_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      interrupt_enable_r <= acc_pkg::RST_INTERRUPT_EN;
    end else if (wr_hit(reg_addr, acc_pkg::ADDR_INTERRUPT_EN)) begin
      interrupt_enable_r <= reg_wdata & 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      int_mask_r <= acc_pkg::RST_INT_MASK;
    end else if (wr_hit(reg_addr, acc_pkg::ADDR_INT_MASK)) begin
      int_mask_r <= reg_wdata & 8'h01;
    end
  end

  // Tracked even while disabled, so enabling never sees a stale edge
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_prev_r <= 1'b0;
    end else begin
      state_prev_r <= state_now;
    end
  end

  // New edge wins over a same-cycle clear
  always_comb begin
    flag_nxt = flag_r;
    if (wr_hit(reg_addr, acc_pkg::ADDR_STATUS) && reg_wdata[acc_pkg::BIT_FLAG]) begin
      flag_nxt = 1'b0;
    end
    if (edge_hit) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // Request built from the flag's next value, so it moves with the flag
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= flag_nxt && interrupt_enable_r[0] && int_mask_r[0];
    end
  end

  // Read data
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        acc_pkg::ADDR_PRIMARY_CONTROL: reg_rdata <= primary_control_r;
        acc_pkg::ADDR_INPUT_SELECT:    reg_rdata <= input_select_r;
        acc_pkg::ADDR_REFERENCE_DIV:   reg_rdata <= reference_div_r;
        acc_pkg::ADDR_INT_MASK:        reg_rdata <= int_mask_r;
        acc_pkg::ADDR_INTERRUPT_EN:    reg_rdata <= interrupt_enable_r;
        acc_pkg::ADDR_STATUS: begin
          reg_rdata <= {3'h0, state_now, 3'h0, flag_r};
        end
        default:                       reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Analog controls, registered so every output is a flop
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      core_enable             <= 1'b0;
      hysteresis_select       <= 2'h0;
      low_power_select        <= 1'b0;
      positive_input_select   <= 2'h0;
      negative_input_select   <= 2'h0;
      divided_reference_level <= acc_pkg::RST_REFERENCE_DIV;
      core_invert             <= 1'b0;
    end else begin
      core_enable             <= enabled;
      hysteresis_select       <= primary_control_r[acc_pkg::BIT_HYS_LO +: 2];
      low_power_select        <= primary_control_r[acc_pkg::BIT_LOW_POWER];
      positive_input_select   <= input_select_r[acc_pkg::BIT_POS_LO +: 2];
      negative_input_select   <= input_select_r[acc_pkg::BIT_NEG_LO +: 2];
      divided_reference_level <= reference_div_r;
      core_invert             <= input_select_r[acc_pkg::BIT_INVERT];
    end
  end

  // Pin copy is synchronised; a purely analog path would be faster
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      out_pin_o    <= 1'b0;
      out_pin_oe_b <= 1'b1;
    end else begin
      out_pin_o    <= state_now && enabled;
      out_pin_oe_b <= !(primary_control_r[acc_pkg::BIT_PIN_DRIVE] && enabled);
    end
  end
endmodule
`default_nettype wire

// ---- acc_comparator_ctrl_props.sv ----
// Port assertions for the comparator control block.
// Assumes one clock domain; bound to every instance.
`timescale 1ns/1ps
`default_nettype none
module acc_comparator_ctrl_props (
  input wire logic       clk_sys,                 // Clock
  input wire logic       rst_b,                   // Reset
  input wire logic [2:0] reg_addr,                // Address
  input wire logic [7:0] reg_wdata,               // Data
  input wire logic       reg_wr,                  // Write
  input wire logic       standby,                 // Sleep
  input wire logic       core_enable,             // Core on
  input wire logic [1:0] hysteresis_select,       // Hysteresis
  input wire logic [1:0] positive_input_select,   // Positive
  input wire logic [1:0] negative_input_select,   // Negative
  input wire logic [7:0] divided_reference_level, // Divider
  input wire logic       core_invert,             // Invert
  input wire logic       out_pin_oe_b,            // Pin enable
  input wire logic       irq                      // Interrupt
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic w0;
  logic w2;
  assign w0 = reg_wr && reg_addr == acc_pkg::ADDR_PRIMARY_CONTROL;
  assign w2 = reg_wr && reg_addr == acc_pkg::ADDR_INPUT_SELECT;
  a_hys_level: assert property (
    w0 |-> ##2 hysteresis_select == $past(reg_wdata[2:1], 2)) else $error("hysteresis");
  a_core_on: assert property (
    w0 && !standby ##1 !standby |-> ##1 core_enable == $past(reg_wdata[0], 2)) else $error("enable");
  a_invert_flag: assert property (
    w2 |-> ##2 core_invert == $past(reg_wdata[7], 2)) else $error("invert");
  a_pos_mux: assert property (
    w2 |-> ##2 positive_input_select == $past(reg_wdata[4:3], 2)) else $error("positive");
  a_neg_mux: assert property (
    w2 |-> ##2 negative_input_select == $past(reg_wdata[1:0], 2)) else $error("negative");
  a_ref_level: assert property (
    reg_wr && reg_addr == acc_pkg::ADDR_REFERENCE_DIV |->
    ##2 divided_reference_level == $past(reg_wdata, 2)) else $error("divider");
  a_irq_drop: assert property (
    $fell(irq) |-> $past(reg_wr, 1) || $past(reg_wr, 2)) else $error("irq drop");
  a_pin_off: assert property (
    w0 && !reg_wdata[6] |-> ##2 out_pin_oe_b) else $error("pin enable");
  cover property (w0 ##2 core_enable);
  cover property ($rose(irq));
  cover property ($fell(irq));
endmodule
bind acc_comparator_ctrl acc_comparator_ctrl_props u_props (.*);
`default_nettype wire

// ---- acc_core_model.sv ----
// Behavioural comparator core: compares the selected levels.
// Assumes all levels are codes on the divider's scale.
`timescale 1ns/1ps
`default_nettype none
module acc_core_model (
  input  wire logic        core_enable, // Core on
  input  wire logic [1:0]  pos_sel,     // Positive select
  input  wire logic [1:0]  neg_sel,     // Negative select
  input  wire logic [7:0]  ref_code,    // Divider code
  input  wire logic [31:0] pos_lvl,     // Positive pins
  input  wire logic [23:0] neg_lvl,     // Negative pins
  output var  logic        core_out     // Raw result
);
  logic [7:0] p;
  logic [7:0] n;
  assign p = pos_lvl[8*pos_sel +: 8];
  assign n = neg_sel == 2'h3 ? ref_code : neg_lvl[8*neg_sel +: 8];
  assign core_out = core_enable && p > n; // Off core reads low
endmodule
`default_nettype wire

// ---- acc_comparator_ctrl_tb.sv ----
// Self-checking bench for the comparator control block.
// Assumes the core model closes the loop to core_out.
`timescale 1ns/1ps
`default_nettype none
module acc_comparator_ctrl_tb;
  logic        clk_sys = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, standby = 1'b0;
  logic [2:0]  reg_addr = 3'h0;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, divided_reference_level;
  logic [1:0]  hysteresis_select, positive_input_select, negative_input_select;
  logic        core_out, core_enable, low_power_select, core_invert, out_pin_o, out_pin_oe_b, irq;
  int          error_cnt = 0, checks_done = 0, cyc = 0;
  localparam logic [2:0] A_CTL = acc_pkg::ADDR_PRIMARY_CONTROL, A_SEL = acc_pkg::ADDR_INPUT_SELECT;
  localparam logic [2:0] A_REF = acc_pkg::ADDR_REFERENCE_DIV, A_STA = acc_pkg::ADDR_STATUS;
  localparam logic [63:0] RST_TAB = 64'h0000_01FF_0000_0000;
  localparam logic [3:0]  RISE = 4'b1001, FALL = 4'b0101;
  acc_comparator_ctrl u_dut (.*);
  acc_core_model u_core (.core_enable(core_enable), .pos_sel(positive_input_select),
    .neg_sel(negative_input_select), .ref_code(divided_reference_level),
    .pos_lvl(32'h8080_8080), .neg_lvl(24'h40_4040), .core_out(core_out));
  initial forever #4 clk_sys = ~clk_sys;
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value at %0t: %h not %h", $time, s, e);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // Flag cleared first so only this edge can set it
  task automatic edge_case(input logic [7:0] r, input logic s, input logic f);
    wr(A_STA, 8'h01);
    wr(A_REF, r);
    idle(7);
    rd(A_STA, {3'h0, s, 3'h0, f});
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      give_verdict;
    end
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++) rd(3'(i), RST_TAB[8*i +: 8]);
    for (int i = 0; i < 4; i++) begin
      wr(A_SEL, {3'h0, 2'(i), 1'b0, 2'(i)});
      wr(A_CTL, {5'h0, 2'(i), 1'b0});
      idle(1);
      chk({positive_input_select, negative_input_select, hysteresis_select, 2'h0},
        {{3{2'(i)}}, 2'h0});
    end
    wr(A_SEL, 8'hFF);
    rd(A_SEL, 8'h9B);
    chk(8'(core_invert), 8'h01);
    wr(A_REF, 8'h5A);
    idle(1);
    chk(divided_reference_level, 8'h5A);
    wr(A_CTL, 8'h01);
    idle(1);
    chk(8'(core_enable), 8'h01);
    @(posedge clk_sys) standby <= 1'b1;
    idle(2);
    chk(8'(core_enable), 8'h00);
    wr(A_CTL, 8'h81);
    idle(1);
    chk(8'(core_enable), 8'h01);
    @(posedge clk_sys) standby <= 1'b0;
    wr(A_SEL, 8'h03);
    wr(A_REF, 8'hFF);
    idle(7);
    for (int m = 0; m < 4; m++) begin
      wr(A_CTL, {2'h0, 2'(m), 4'h1});
      edge_case(8'h00, 1'b1, RISE[m]);
      edge_case(8'hFF, 1'b0, FALL[m]);
    end
    wr(A_CTL, 8'h01);
    edge_case(8'h00, 1'b1, 1'b1);
    wr(A_STA, 8'h00);
    rd(A_STA, 8'h11);
    wr(acc_pkg::ADDR_INTERRUPT_EN, 8'h01);
    idle(1);
    chk(8'(irq), 8'h01);
    wr(acc_pkg::ADDR_INT_MASK, 8'h00);
    idle(1);
    chk(8'(irq), 8'h00);
    wr(acc_pkg::ADDR_INT_MASK, 8'h01);
    idle(5);
    chk(8'(irq), 8'h01);
    wr(A_STA, 8'h01);
    idle(1);
    chk(8'(irq), 8'h00);
    wr(A_SEL, 8'h83);
    wr(A_CTL, 8'h41);
    idle(7);
    rd(A_STA, 8'h01);
    chk(8'({out_pin_oe_b, out_pin_o}), 8'h00);
    wr(A_SEL, 8'h03);
    idle(3);
    chk(8'({out_pin_oe_b, out_pin_o}), 8'h01);
    // Output falls only after the core is off, so no flag may follow
    wr(A_CTL, 8'h08);
    wr(A_STA, 8'h01);
    idle(7);
    rd(A_STA, 8'h00);
    chk(8'({low_power_select, core_enable, irq}), 8'h04);
    give_verdict;
  end
endmodule
`default_nettype wire
